// file: adsc_ctrl.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module adsc_ctrl
    import adsc_pkg::*;
#(
    parameter int NCELL = 15
)(
    input  wire logic              I_REF_CLK,
    input  wire logic              I_NRST,
    input  wire logic              I_WB_CYC,
    input  wire logic              I_WB_STB,
    input  wire logic              I_WB_WE,
    input  wire logic [7:0]        I_WB_ADR,
    input  wire logic [1:0]        I_WB_SEL,
    input  wire logic [15:0]       I_WB_DAT,
    output logic      [15:0]       O_WB_DAT,
    output logic                   O_WB_ACK,
    input  wire logic              I_ACQ_DONE,
    input  wire logic              I_FULL_RESULT_A_VALID,
    input  wire logic [15:0]       I_FULL_RESULT_A_DATA,
    input  wire logic [NCELL-1:0]  I_CELL_POLARITY,
    output logic      [NCELL-1:0]  O_CURRENT_SRC_EN,
    output logic      [NCELL-1:0]  O_CELL_MEASURE,
    output logic                   O_OPEN_WIRE_MODE,
    output logic                   O_LOW_SIDE_ONLY,
    output logic                   O_ALT_OPEN_THRESH,
    output logic                   O_FULL_RESULT_A_REQUEST,
    output adsc_route_t            O_ROUTE
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0]      cur_cfg_q;
    logic [15:0]      cur_cfg_d;
    logic [15:0]      full_result_a_cfg_q;
    logic [15:0]      full_result_a_cfg_d;
    logic [NCELL-1:0] chan_en_q;
    logic [NCELL-1:0] chan_en_d;
    logic [15:0]      result_q;
    logic [15:0]      full_q;
    logic [15:0]      alert_q;
    logic [15:0]      alert_d;
    logic             ack_q;
    logic [15:0]      rdat_q;
    logic             pend_q;
    logic [3:0]       pend_sel_q;
    adsc_route_t      route;
    adsc_wb_req_t     req;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire              bus_req    = I_WB_CYC & I_WB_STB & ~ack_q;
    wire              bus_wr     = bus_req & I_WB_WE;
    wire              hit_cur    = (I_WB_ADR == ADDR_CELL_TEST_CURRENT_CFG);
    wire              hit_cfg    = (I_WB_ADR == ADDR_FULL_RESULT_A_CFG);
    wire              hit_res    = (I_WB_ADR == ADDR_FIRST_FULL_RESULT_A_RESULT);
    wire              hit_full   = (I_WB_ADR == ADDR_FULL_RESULT_A);
    wire              hit_alert  = (I_WB_ADR == ADDR_FAILURE_ALERT_REG_TWO);
    wire              hit_chan   = (I_WB_ADR == ADDR_CHANNEL_CFG);
    wire              hit_route  = (I_WB_ADR == ADDR_FULL_RESULT_A_ROUTE);
    wire [15:0]       byte_mask  = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
    wire [15:0]       chan_word  = 16'(chan_en_q);
    // the route struct is wider than the bus, only its low 16 bits read back
    wire [$bits(adsc_route_t)-1:0] route_bits = route;
    wire [15:0]       route_word = route_bits[15:0];

    assign req.adr = I_WB_ADR;
    assign req.dat = I_WB_DAT;
    assign req.sel = I_WB_SEL;
    assign req.we  = I_WB_WE;

    // unmapped addresses still ack and read zero, so software never hangs
    wire [15:0] rd_mux =
        hit_cur   ? cur_cfg_q  :
        hit_cfg   ? full_result_a_cfg_q :
        hit_res   ? result_q   :
        hit_full  ? full_q     :
        hit_alert ? alert_q    :
        hit_chan  ? chan_word  :
        hit_route ? route_word : 16'h0000;

    // ************************************************************
    // writes
    // ************************************************************
    wire [15:0] wr_mask = bus_wr ? byte_mask : 16'h0000;

    assign cur_cfg_d  = hit_cur ? ((cur_cfg_q & ~wr_mask) | (req.dat & wr_mask))
                                : cur_cfg_q;
    assign full_result_a_cfg_d = hit_cfg ? ((full_result_a_cfg_q & ~wr_mask) | (req.dat & wr_mask))
                                : full_result_a_cfg_q;
    wire [15:0] chan_new = (chan_word & ~wr_mask) | (req.dat & wr_mask);
    assign chan_en_d  = hit_chan ? chan_new[NCELL-1:0] : chan_en_q;

    // ************************************************************
    // diagnostic selection
    // ************************************************************
    wire [3:0] sel_code = full_result_a_cfg_q[POS_SEL_HI:0];
    wire       cal_en   = full_result_a_cfg_q[POS_CAL_ENABLE];
    wire [1:0] scan     = full_result_a_cfg_q[POS_SCAN_LO+1:POS_SCAN_LO];

    adsc_decode u_decode (
        .i_sel    (sel_code),
        .i_cal_en (cal_en),
        .i_scan   (scan),
        .o_route  (route)
    );

    // the selection is latched per acquisition so a mid-sequence write
    // cannot redirect a result already being measured
    wire start_full_result_a = I_ACQ_DONE & (sel_code != DSEL_NONE);
    wire take_res   = pend_q & I_FULL_RESULT_A_VALID;
    wire is_detail  = (pend_sel_q == DSEL_ZERO_SC) | (pend_sel_q == DSEL_FULL_SC);

    // ************************************************************
    // built-in self-test alerts
    // ************************************************************
    // window check instead of exact match, the adc carries a little noise
    wire [15:0] expect_val = (pend_sel_q == DSEL_ZERO_SC) ? EXP_ZERO_SC : EXP_FULL_SC;
    wire [15:0] diff_val   = (I_FULL_RESULT_A_DATA > expect_val) ? (I_FULL_RESULT_A_DATA - expect_val)
                                                        : (expect_val - I_FULL_RESULT_A_DATA);
    wire        bist_fail  = (diff_val > BIST_TOL);
    wire        set_zero   = take_res & is_detail & bist_fail & (pend_sel_q == DSEL_ZERO_SC);
    wire        set_full   = take_res & is_detail & bist_fail & (pend_sel_q == DSEL_FULL_SC);
    wire [15:0] alert_set  = {14'h0000, set_full, set_zero};
    wire [15:0] alert_clr  = (hit_alert & bus_wr) ? (req.dat & byte_mask) : 16'h0000;

    // set wins over a write-one-to-clear in the same cycle
    assign alert_d = (alert_q & ~alert_clr) | alert_set;

    // ************************************************************
    // open-wire channel selection
    // ************************************************************
    wire open_wire = cur_cfg_q[POS_OPEN_WIRE];

    assign O_CURRENT_SRC_EN  = cur_cfg_q[NCELL-1:0];
    assign O_OPEN_WIRE_MODE  = open_wire;
    assign O_CELL_MEASURE    = open_wire ? (chan_en_q & ~I_CELL_POLARITY) : chan_en_q;
    assign O_LOW_SIDE_ONLY   = open_wire;
    assign O_ALT_OPEN_THRESH = open_wire;
    assign O_FULL_RESULT_A_REQUEST    = pend_q;
    assign O_ROUTE           = route;
    assign O_WB_DAT          = rdat_q;
    assign O_WB_ACK          = ack_q;

    // ************************************************************
    // flops
    // ************************************************************
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cur_cfg_q  <= RST_CELL_TEST_CURRENT_CFG;
            full_result_a_cfg_q <= RST_FULL_RESULT_A_CFG;
            chan_en_q  <= '0;
            alert_q    <= 16'h0000;
        end else begin
            cur_cfg_q  <= cur_cfg_d;
            full_result_a_cfg_q <= full_result_a_cfg_d;
            chan_en_q  <= chan_en_d;
            alert_q    <= alert_d;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ack_q  <= 1'b0;
            rdat_q <= 16'h0000;
        end else begin
            ack_q  <= bus_req;
            rdat_q <= bus_req ? rd_mux : 16'h0000;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pend_q     <= 1'b0;
            pend_sel_q <= DSEL_NONE;
        end else if (start_full_result_a) begin
            pend_q     <= 1'b1;
            pend_sel_q <= sel_code;
        end else if (take_res) begin
            pend_q     <= 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            result_q <= 16'h0000;
            full_q   <= 16'h0000;
        end else if (take_res) begin
            result_q <= I_FULL_RESULT_A_DATA;
            if (is_detail) begin
                full_q <= I_FULL_RESULT_A_DATA;
            end
        end
    end
endmodule

// file: adsc_pkg.sv
package adsc_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  ADDR_CELL_TEST_CURRENT_CFG = 8'h6c;
    localparam logic [7:0]  ADDR_FULL_RESULT_A_CFG              = 8'h70;
    localparam logic [7:0]  ADDR_FIRST_FULL_RESULT_A_RESULT     = 8'h71;
    localparam logic [7:0]  ADDR_FULL_RESULT_A         = 8'h72;
    localparam logic [7:0]  ADDR_FAILURE_ALERT_REG_TWO = 8'h73;
    localparam logic [7:0]  ADDR_CHANNEL_CFG           = 8'h74;
    localparam logic [7:0]  ADDR_FULL_RESULT_A_ROUTE            = 8'h75;
    localparam logic [15:0] RST_CELL_TEST_CURRENT_CFG  = 16'h0000;
    localparam logic [15:0] RST_FULL_RESULT_A_CFG               = 16'h0000;
    localparam int          POS_OPEN_WIRE              = 15;
    localparam int          POS_CAL_ENABLE             = 4;
    localparam int          POS_SCAN_LO                = 5;
    localparam int          POS_SEL_HI                 = 3;
    // ************************************************************
    // diagnostic codes and figures
    // ************************************************************
    localparam logic [3:0]  DSEL_NONE      = 4'h0;
    localparam logic [3:0]  DSEL_DIE_TEMP  = 4'h1;
    localparam logic [3:0]  DSEL_VAA       = 4'h2;
    localparam logic [3:0]  DSEL_ALTREF    = 4'h3;
    localparam logic [3:0]  DSEL_COMP_PATH = 4'h4;
    localparam logic [3:0]  DSEL_CELL_CAL  = 4'h5;
    localparam logic [3:0]  DSEL_OFS_CAL   = 4'h6;
    localparam logic [3:0]  DSEL_DAC_3Q    = 4'h7;
    localparam logic [3:0]  DSEL_DAC_1Q    = 4'h8;
    localparam logic [3:0]  DSEL_THRM_OFS  = 4'h9;
    localparam logic [3:0]  DSEL_ZERO_SC   = 4'ha;
    localparam logic [3:0]  DSEL_FULL_SC   = 4'hb;
    localparam logic [3:0]  DSEL_LSA_OFS   = 4'hc;
    localparam logic [3:0]  DSEL_VDDL      = 4'hd;
    localparam logic [11:0] DAC_COMP_PATH  = 12'h400;
    localparam logic [11:0] DAC_3Q         = 12'hc00;
    localparam logic [11:0] DAC_1Q         = 12'h3ff;
    localparam logic [15:0] EXP_ZERO_SC    = 16'h0000;
    localparam logic [15:0] EXP_FULL_SC    = 16'h3ffc;
    localparam logic [15:0] BIST_TOL       = 16'h0010;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        ADSC_IN_NONE, ADSC_IN_PTAT, ADSC_IN_REF_LSA, ADSC_IN_ALTREF,
        ADSC_IN_REF_MINUS_DAC, ADSC_IN_SHORT, ADSC_IN_DAC, ADSC_IN_AA
    } adsc_in_t;
    typedef enum logic [1:0] {
        ADSC_COEF_NONE, ADSC_COEF_GAIN_OFS, ADSC_COEF_OFS, ADSC_COEF_THRM
    } adsc_coef_t;
    typedef struct packed {
        adsc_in_t    adc_in;
        adsc_coef_t  coef;
        logic        factory_coef;
        logic        bipolar;
        logic        chop;
        logic [11:0] dac_code;
        logic [1:0]  scan_mode;
    } adsc_route_t;
    typedef struct packed {
        logic [7:0]  adr;
        logic [15:0] dat;
        logic [1:0]  sel;
        logic        we;
    } adsc_wb_req_t;
endpackage

// file: adsc_decode.sv
`timescale 1ns/10ps
module adsc_decode
    import adsc_pkg::*;
(
    input  wire logic [3:0]  i_sel,
    input  wire logic        i_cal_en,
    input  wire logic [1:0]  i_scan,
    output adsc_route_t      o_route
);
    // ************************************************************
    // selection code to measurement routing
    // ************************************************************
    always_comb begin
        o_route              = '0;
        o_route.adc_in       = ADSC_IN_NONE;
        o_route.coef         = ADSC_COEF_NONE;
        o_route.scan_mode    = i_scan;
        o_route.factory_coef = ~i_cal_en;
        o_route.chop         = (i_sel != DSEL_NONE);
        unique case (i_sel)
            DSEL_DIE_TEMP: o_route.adc_in = ADSC_IN_PTAT;
            DSEL_VAA:      o_route.adc_in = ADSC_IN_REF_LSA;
            DSEL_ALTREF:   o_route.adc_in = ADSC_IN_ALTREF;
            DSEL_COMP_PATH: begin
                o_route.adc_in   = ADSC_IN_REF_MINUS_DAC;
                o_route.dac_code = DAC_COMP_PATH;
                o_route.bipolar  = 1'b1;
            end
            DSEL_CELL_CAL: begin
                o_route.adc_in = ADSC_IN_REF_LSA;
                o_route.coef   = ADSC_COEF_GAIN_OFS;
            end
            DSEL_OFS_CAL: begin
                o_route.adc_in  = ADSC_IN_SHORT;
                o_route.coef    = ADSC_COEF_OFS;
                o_route.bipolar = 1'b1;
            end
            DSEL_DAC_3Q: begin
                o_route.adc_in   = ADSC_IN_DAC;
                o_route.dac_code = DAC_3Q;
            end
            DSEL_DAC_1Q: begin
                o_route.adc_in   = ADSC_IN_DAC;
                o_route.dac_code = DAC_1Q;
            end
            DSEL_THRM_OFS: begin
                o_route.adc_in  = ADSC_IN_SHORT;
                o_route.coef    = ADSC_COEF_THRM;
                o_route.bipolar = 1'b1;
            end
            DSEL_ZERO_SC, DSEL_FULL_SC: begin
                o_route.adc_in  = ADSC_IN_AA;
                o_route.bipolar = 1'b1;
            end
            DSEL_LSA_OFS: begin
                o_route.adc_in  = ADSC_IN_SHORT;
                o_route.bipolar = 1'b1;
            end
            DSEL_VDDL: o_route.adc_in = ADSC_IN_REF_LSA;
            default: begin
                o_route.chop = 1'b0;
            end
        endcase
    end
endmodule

// file: adsc_ctrl_props.sv
`timescale 1ns/10ps
module adsc_ctrl_props
    import adsc_pkg::*;
#(
    parameter int NCELL = 15
)(
    input wire logic              I_REF_CLK,
    input wire logic              I_NRST,
    input wire logic              I_WB_CYC,
    input wire logic              I_WB_STB,
    input wire logic              I_WB_WE,
    input wire logic [7:0]        I_WB_ADR,
    input wire logic [1:0]        I_WB_SEL,
    input wire logic [15:0]       I_WB_DAT,
    input wire logic [15:0]       O_WB_DAT,
    input wire logic              O_WB_ACK,
    input wire logic              I_ACQ_DONE,
    input wire logic              I_FULL_RESULT_A_VALID,
    input wire logic [15:0]       I_FULL_RESULT_A_DATA,
    input wire logic [NCELL-1:0]  I_CELL_POLARITY,
    input wire logic [NCELL-1:0]  O_CURRENT_SRC_EN,
    input wire logic [NCELL-1:0]  O_CELL_MEASURE,
    input wire logic              O_OPEN_WIRE_MODE,
    input wire logic              O_LOW_SIDE_ONLY,
    input wire logic              O_ALT_OPEN_THRESH,
    input wire logic              O_FULL_RESULT_A_REQUEST,
    input adsc_route_t            O_ROUTE
);
    // ************************************************************
    // bus and diagnostic properties
    // ************************************************************
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_NRST);
    property p_ack_resp; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
    property p_ack_pulse; O_WB_ACK |=> !O_WB_ACK; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_rd_idle; !O_WB_ACK |-> O_WB_DAT == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without ack");
    // a full-width write reaches the current sources on the next edge
    property p_src_en; I_WB_CYC && I_WB_STB && !O_WB_ACK && I_WB_WE && I_WB_SEL == 2'h3 &&
        I_WB_ADR == ADDR_CELL_TEST_CURRENT_CFG |=>
        O_CURRENT_SRC_EN == $past(I_WB_DAT[NCELL-1:0]); endproperty
    a_src_en: assert property (p_src_en) else $error("current source enables wrong");
    property p_ow_mode; O_LOW_SIDE_ONLY == O_OPEN_WIRE_MODE && O_ALT_OPEN_THRESH == O_OPEN_WIRE_MODE; endproperty
    a_ow_mode: assert property (p_ow_mode) else $error("open-wire outputs disagree");
    property p_ow_meas; O_OPEN_WIRE_MODE |-> (O_CELL_MEASURE & I_CELL_POLARITY) == '0; endproperty
    a_ow_meas: assert property (p_ow_meas) else $error("reversed cell measured");
    property p_req_set; I_ACQ_DONE && O_ROUTE.adc_in != ADSC_IN_NONE |=> O_FULL_RESULT_A_REQUEST; endproperty
    a_req_set: assert property (p_req_set) else $error("diagnostic not requested");
    property p_req_clr; I_FULL_RESULT_A_VALID && !I_ACQ_DONE |=> !O_FULL_RESULT_A_REQUEST; endproperty
    a_req_clr: assert property (p_req_clr) else $error("request not cleared");
    property p_dac; O_ROUTE.adc_in == ADSC_IN_REF_MINUS_DAC |->
        O_ROUTE.dac_code == DAC_COMP_PATH && O_ROUTE.bipolar; endproperty
    a_dac: assert property (p_dac) else $error("comparator path dac wrong");
endmodule
bind adsc_ctrl adsc_ctrl_props #(.NCELL(NCELL)) u_props (.*);

// file: testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module testbench import adsc_pkg::*;;
    typedef struct packed {
        logic [3:0]  code;
        adsc_in_t    ain;
        adsc_coef_t  cf;
        logic [11:0] dac;
        logic        bip;
        logic [2:0]  chk;
    } adsc_row_t;
    logic          clk, nrst, cs, ack, acq, dvalid, ow, lso, alt, dreq;
    adsc_wb_req_t  req;
    logic [15:0]   rdat, ddata, rd;
    logic [14:0]   pol, src_en, meas;
    adsc_route_t   route;
    int            miscompares, n_tests, tick;
    // chk bits: adc input, coefficient set, dac code
    adsc_row_t     rows [14] = '{
        '{4'h0, ADSC_IN_NONE, ADSC_COEF_NONE, 12'h000, 1'b0, 3'b100},
        '{4'h1, ADSC_IN_PTAT, ADSC_COEF_NONE, 12'h000, 1'b0, 3'b100},
        '{4'h2, ADSC_IN_REF_LSA, ADSC_COEF_NONE, 12'h000, 1'b0, 3'b100},
        '{4'h3, ADSC_IN_ALTREF, ADSC_COEF_NONE, 12'h000, 1'b0, 3'b100},
        '{4'h4, ADSC_IN_REF_MINUS_DAC, ADSC_COEF_NONE, 12'h400, 1'b1, 3'b101},
        '{4'h5, ADSC_IN_REF_LSA, ADSC_COEF_GAIN_OFS, 12'h000, 1'b0, 3'b110},
        '{4'h6, ADSC_IN_SHORT, ADSC_COEF_OFS, 12'h000, 1'b1, 3'b110},
        '{4'h7, ADSC_IN_DAC, ADSC_COEF_NONE, 12'hc00, 1'b0, 3'b101},
        '{4'h8, ADSC_IN_DAC, ADSC_COEF_NONE, 12'h3ff, 1'b0, 3'b101},
        '{4'h9, ADSC_IN_SHORT, ADSC_COEF_THRM, 12'h000, 1'b1, 3'b110},
        '{4'ha, ADSC_IN_AA, ADSC_COEF_NONE, 12'h000, 1'b1, 3'b100},
        '{4'hb, ADSC_IN_AA, ADSC_COEF_NONE, 12'h000, 1'b1, 3'b100},
        '{4'hc, ADSC_IN_SHORT, ADSC_COEF_NONE, 12'h000, 1'b1, 3'b100},
        '{4'hd, ADSC_IN_REF_LSA, ADSC_COEF_NONE, 12'h000, 1'b0, 3'b100}};
    adsc_ctrl #(.NCELL(15)) dut (
        .I_REF_CLK(clk), .I_NRST(nrst), .I_WB_CYC(cs), .I_WB_STB(cs), .I_WB_WE(req.we),
        .I_WB_ADR(req.adr), .I_WB_SEL(req.sel), .I_WB_DAT(req.dat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .I_ACQ_DONE(acq), .I_FULL_RESULT_A_VALID(dvalid), .I_FULL_RESULT_A_DATA(ddata),
        .I_CELL_POLARITY(pol), .O_CURRENT_SRC_EN(src_en), .O_CELL_MEASURE(meas),
        .O_OPEN_WIRE_MODE(ow), .O_LOW_SIDE_ONLY(lso), .O_ALT_OPEN_THRESH(alt),
        .O_FULL_RESULT_A_REQUEST(dreq), .O_ROUTE(route));
    // ************************************************************
    // bus and diagnostic tasks
    // ************************************************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] s, output logic [15:0] q);
        @(posedge clk);
        cs <= 1'b1;
        req <= '{a, d, s, w};
        // no cycle count assumed, only the bench ceiling ends a hung wait
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cs <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, d, 2'h3, rd);
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000, 2'h3, rd);
        `CHK("readback", e, rd)
    endtask
    // acquisition end, then the measured value one handshake later
    task automatic full_result_a(input logic [3:0] c, input logic [15:0] d);
        wr(ADDR_FULL_RESULT_A_CFG, {12'h001, c});
        @(posedge clk) acq <= 1'b1;
        @(posedge clk) acq <= 1'b0;
        @(posedge clk);
        `CHK("request", c != 4'h0, dreq)
        ddata <= d;
        dvalid <= 1'b1;
        @(posedge clk) dvalid <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("request_clear", 1'b0, dreq)
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge clk) begin
        tick++;
        if (tick == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {nrst, cs, acq, dvalid, req, ddata, pol} = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rc(ADDR_CELL_TEST_CURRENT_CFG, RST_CELL_TEST_CURRENT_CFG);
        `CHK("src_en_rst", 15'h0000, src_en)
        `CHK("open_wire_rst", 1'b0, ow)
        foreach (rows[i]) begin
            wr(ADDR_FULL_RESULT_A_CFG, {9'h000, 2'b01, 1'b1, rows[i].code});
            repeat (2) @(posedge clk);
            `CHK("factory", 1'b0, route.factory_coef)
            `CHK("scan", 2'b01, route.scan_mode)
            if (rows[i].chk[2]) `CHK("adc_in", rows[i].ain, route.adc_in)
            if (rows[i].chk[1]) `CHK("coef", rows[i].cf, route.coef)
            if (rows[i].chk[0]) `CHK("dac", rows[i].dac, route.dac_code)
            `CHK("bipolar", rows[i].bip, route.bipolar)
            `CHK("chop", rows[i].code != 4'h0, route.chop)
        end
        wr(ADDR_FULL_RESULT_A_CFG, 16'h0005);
        repeat (2) @(posedge clk);
        `CHK("factory_off", 1'b1, route.factory_coef)
        rc(ADDR_FULL_RESULT_A_ROUTE, 16'h4000);
        wr(ADDR_CELL_TEST_CURRENT_CFG, 16'hffff);
        rc(ADDR_CELL_TEST_CURRENT_CFG, 16'hffff);
        wr(ADDR_CHANNEL_CFG, 16'h7fff);
        pol <= 15'h5555;
        repeat (2) @(posedge clk);
        `CHK("src_en", 15'h7fff, src_en)
        `CHK("modes", 3'b111, {ow, lso, alt})
        `CHK("measure_ow", 15'h2aaa, meas)
        rc(ADDR_CHANNEL_CFG, 16'h7fff);
        wb(1'b1, ADDR_CELL_TEST_CURRENT_CFG, 16'h0000, 2'h2, rd);
        rc(ADDR_CELL_TEST_CURRENT_CFG, 16'h00ff);
        `CHK("measure_norm", 15'h7fff, meas)
        wr(8'h20, 16'hffff);
        rc(8'h20, 16'h0000);
        full_result_a(4'hb, 16'h3ffc);
        rc(ADDR_FIRST_FULL_RESULT_A_RESULT, 16'h3ffc);
        rc(ADDR_FULL_RESULT_A, 16'h3ffc);
        rc(ADDR_FAILURE_ALERT_REG_TWO, 16'h0000);
        full_result_a(4'ha, 16'h0100);
        rc(ADDR_FULL_RESULT_A, 16'h0100);
        rc(ADDR_FAILURE_ALERT_REG_TWO, 16'h0001);
        full_result_a(4'hb, 16'h2000);
        rc(ADDR_FAILURE_ALERT_REG_TWO, 16'h0003);
        wr(ADDR_FAILURE_ALERT_REG_TWO, 16'h0001);
        rc(ADDR_FAILURE_ALERT_REG_TWO, 16'h0002);
        full_result_a(4'hc, 16'h7777);
        rc(ADDR_FAILURE_ALERT_REG_TWO, 16'h0002);
        rc(ADDR_FIRST_FULL_RESULT_A_RESULT, 16'h7777);
        full_result_a(4'h3, 16'h0abc);
        rc(ADDR_FIRST_FULL_RESULT_A_RESULT, 16'h0abc);
        full_result_a(4'h0, 16'h1234);
        rc(ADDR_FIRST_FULL_RESULT_A_RESULT, 16'h0abc);
        wr(ADDR_CELL_TEST_CURRENT_CFG, 16'hffff);
        @(posedge clk) nrst <= 1'b0;
        repeat (2) @(posedge clk) nrst <= 1'b1;
        rc(ADDR_CELL_TEST_CURRENT_CFG, 16'h0000);
        `CHK("src_en_rerst", 15'h0000, src_en)
        `CHK("open_wire_rerst", 1'b0, ow)
        rc(ADDR_FAILURE_ALERT_REG_TWO, 16'h0000);
        finish_test();
    end
endmodule
